// file: core/uartc_map.svh
`ifndef UARTC_MAP_SVH
`define UARTC_MAP_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define UC_OFS_MODE     4'h0
`define UC_OFS_TXSTAT   4'h4
`define UC_OFS_TXBUF    4'h8
`define UC_OFS_RXBUF    4'hC

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define UC_BIT_POWER    7
`define UC_BIT_TXE      6
`define UC_BIT_RXE      5
`define UC_BIT_TXBF     1
`define UC_BIT_TXSF     0
`define UC_BIT_RXRDY    8

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define UC_RST_MODE     3'h0
`define UC_RST_BYTE     8'h00

// ---------------------------------------------------------------
// Timing counts and bus response codes
// ---------------------------------------------------------------
`define UC_BASE_DIV     2'h3
`define UC_BIT_TICKS    4'hF
`define UC_HALF_TICKS   4'h7
`define UC_GAP_TICKS    2'h2
`define UC_RESP_OKAY    2'h0
`define UC_RESP_SLVERR  2'h2

`endif

// file: core/uartc_pkg.sv
package uartc_pkg;
  // Transmit engine states
  typedef enum logic [2:0] {
    TX_IDLE,
    TX_GAP,
    TX_START,
    TX_DATA,
    TX_STOP
  } uartc_tx_e;
  // Receive engine states
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } uartc_rx_e;
  // Register select
  typedef enum logic [2:0] {
    SEL_MODE,
    SEL_TXSTAT,
    SEL_TXBUF,
    SEL_RXBUF,
    SEL_NONE
  } uartc_sel_e;
  typedef logic [7:0] uartc_byte_t;
endpackage

// file: core/uartc_top.sv
// Overview of operation
// (R1) Running unit clock keeps normal operation
// (R2) Stopped clock freezes every register
// (R3) Output pin holds level while stopped
// (R4) Software clears power and enables after restart
// (R5) Back-to-back frames gain two clocks gap
// (R6) Receiver restarts timing at each start
// (R7) Software avoids back-to-back mode for LIN
// (R8) Receive enable takes effect one period later
// (R9) Software waits one period before first write
// (R10) No buffer write while full flag set
// (R11) No buffer rewrite during communication
// (R12) Power on first, transmit enable off first
// (R13) Enable reception only while input high
// (R14) Output pin idles high when disabled
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "uartc_map.svh"

module uartc_top (
  input  wire logic        sys_clk,        // 50 MHz system clock
  input  wire logic        nrst,           // Sync reset, active low
  input  wire logic        unit_clk_run,   // Unit clock supplied
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,   // Write address
  input  wire logic        s_axi_awvalid,  // Write address valid
  output logic             s_axi_awready,  // Write address ready
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,    // Write data
  input  wire logic [3:0]  s_axi_wstrb,    // Byte enables
  input  wire logic        s_axi_wvalid,   // Write data valid
  output logic             s_axi_wready,   // Write data ready
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,    // Write response
  output logic             s_axi_bvalid,   // Write response valid
  input  wire logic        s_axi_bready,   // Write response ready
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,   // Read address
  input  wire logic        s_axi_arvalid,  // Read address valid
  output logic             s_axi_arready,  // Read address ready
  output logic [31:0]      s_axi_rdata,    // Read data
  output logic [1:0]       s_axi_rresp,    // Read response
  output logic             s_axi_rvalid,   // Read data valid
  input  wire logic        s_axi_rready,   // Read data ready
  // Serial pins
  input  wire logic        serial_input_pin,  // Receive line
  output logic             serial_output_pin  // Transmit line
);
  import uartc_pkg::*;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Shared by read and write paths
  function automatic uartc_sel_e reg_sel(input logic [3:0] addr);
    case (addr)
      `UC_OFS_MODE:   reg_sel = SEL_MODE;
      `UC_OFS_TXSTAT: reg_sel = SEL_TXSTAT;
      `UC_OFS_TXBUF:  reg_sel = SEL_TXBUF;
      `UC_OFS_RXBUF:  reg_sel = SEL_RXBUF;
      default:        reg_sel = SEL_NONE;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic        power_reg;              // Unit power on bit
  logic        txe_reg;                // Transmit enable bit
  logic        rxe_reg;                // Receive enable bit
  uartc_byte_t txb_reg;                // Transmit buffer
  logic        txbf_reg;               // Transmit buffer full flag
  uartc_byte_t rxb_reg;                // Receive buffer
  logic        rxrdy_reg;              // Receive buffer holds data
  logic [1:0]  div_reg;                // Base clock divider
  logic        rx_wait_reg;            // Enable seen, waiting a period
  logic        rx_on_reg;              // Reception enabled state
  uartc_rx_e   rx_state_reg;           // Receive engine state
  logic [3:0]  rx_tick_reg;            // Ticks within a bit
  logic [2:0]  rx_idx_reg;             // Receive bit index
  uartc_byte_t rx_shf_reg;             // Receive shift register
  logic        aw_got_reg;             // Address held
  logic        w_got_reg;              // Data held
  logic [3:0]  aw_addr_reg;            // Held write address
  logic [31:0] w_data_reg;             // Held write data
  logic        w_lane0_reg;            // Held low byte enable
  logic        bvalid_reg;             // Response pending
  logic [1:0]  bresp_reg;              // Response code
  logic        rvalid_reg;             // Read data pending
  logic [31:0] rdata_reg;              // Read data
  logic [1:0]  rresp_reg;              // Read response
  wire         base_tick;              // One pulse per base period
  wire         tx_en;                  // Transmitter enabled
  wire         tx_take;                // Buffer moved to shifter
  wire         tx_busy;                // Transmit frame running
  wire         aw_fire;                // Address taken
  wire         w_fire;                 // Data taken
  wire         wr_do;                  // Write performed
  wire         ar_fire;                // Read taken
  wire         rx_bit_end;             // Last tick of receive bit
  wire         rx_mid;                 // Middle of start bit
  uartc_sel_e  wr_sel;                 // Write target
  uartc_sel_e  rd_sel;                 // Read target
  logic [31:0] rd_word;                // Read mux output

  // ---------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------
  // A frozen unit leaves the bus waiting; limitation of the clock stop
  assign s_axi_awready = unit_clk_run && !aw_got_reg && !bvalid_reg;
  assign s_axi_wready  = unit_clk_run && !w_got_reg && !bvalid_reg;
  assign s_axi_arready = unit_clk_run && !rvalid_reg;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign wr_do         = unit_clk_run && aw_got_reg && w_got_reg && !bvalid_reg;
  assign wr_sel        = reg_sel(aw_addr_reg);
  assign rd_sel        = reg_sel(s_axi_araddr);
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Read mux; unused upper bits read as zero
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_sel)
      SEL_MODE: begin
        rd_word[`UC_BIT_POWER] = power_reg;
        rd_word[`UC_BIT_TXE]   = txe_reg;
        rd_word[`UC_BIT_RXE]   = rxe_reg;
      end
      SEL_TXSTAT: begin
        rd_word[`UC_BIT_TXBF] = txbf_reg;
        rd_word[`UC_BIT_TXSF] = tx_busy;
      end
      SEL_TXBUF: rd_word[7:0] = txb_reg;
      SEL_RXBUF: begin
        rd_word[7:0]          = rxb_reg;
        rd_word[`UC_BIT_RXRDY] = rxrdy_reg;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Address and data may arrive in either order
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 32'h0000_0000;
      w_lane0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `UC_RESP_OKAY;
    end else if (unit_clk_run) begin
      if (aw_fire) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_got_reg   <= 1'b1;
        w_data_reg  <= s_axi_wdata;
        w_lane0_reg <= s_axi_wstrb[0];
      end
      if (wr_do) begin
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg  <= (wr_sel == SEL_NONE) ? `UC_RESP_SLVERR : `UC_RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= `UC_RESP_OKAY;
    end else if (unit_clk_run) begin
      if (ar_fire) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= (rd_sel == SEL_NONE) ? `UC_RESP_SLVERR : `UC_RESP_OKAY;
      end else if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers and buffers
  // ---------------------------------------------------------------
  assign tx_en = power_reg && txe_reg;

  // (R2) frozen when clock stops
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      {power_reg, txe_reg, rxe_reg} <= `UC_RST_MODE;
      txb_reg  <= `UC_RST_BYTE;
      txbf_reg <= 1'b0;
    end else if (unit_clk_run) begin
      if (wr_do && w_lane0_reg && wr_sel == SEL_MODE) begin
        power_reg <= w_data_reg[`UC_BIT_POWER];
        txe_reg   <= w_data_reg[`UC_BIT_TXE];
        rxe_reg   <= w_data_reg[`UC_BIT_RXE];
      end
      // New data wins over the hand-off in the same cycle
      if (wr_do && w_lane0_reg && wr_sel == SEL_TXBUF) begin
        txb_reg  <= w_data_reg[7:0];
        txbf_reg <= 1'b1;
      end else if (tx_take || !tx_en) begin
        txbf_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Base clock
  // ---------------------------------------------------------------
  assign base_tick = unit_clk_run && (div_reg == `UC_BASE_DIV);

  // Free divider, held only by the clock stop
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_reg <= 2'h0;
    end else if (unit_clk_run) begin
      div_reg <= base_tick ? 2'h0 : div_reg + 2'h1;
    end
  end

  // ---------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------
  assign rx_bit_end = base_tick && (rx_tick_reg == `UC_BIT_TICKS);
  assign rx_mid     = base_tick && (rx_tick_reg == `UC_HALF_TICKS);

  // (R8) enable after one base period
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_wait_reg <= 1'b0;
      rx_on_reg   <= 1'b0;
    end else if (unit_clk_run) begin
      if (!(power_reg && rxe_reg)) begin
        rx_wait_reg <= 1'b0;
        rx_on_reg   <= 1'b0;
      end else if (base_tick) begin
        rx_wait_reg <= 1'b1;
        rx_on_reg   <= rx_wait_reg;
      end
    end
  end

  // Receive engine, samples mid bit
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rx_state_reg <= RX_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_idx_reg   <= 3'h0;
      rx_shf_reg   <= `UC_RST_BYTE;
      rxb_reg      <= `UC_RST_BYTE;
      rxrdy_reg    <= 1'b0;
    end else if (unit_clk_run) begin
      if (base_tick) begin
        rx_tick_reg <= rx_tick_reg + 4'h1;
      end
      // Read of the buffer releases it
      if (ar_fire && rd_sel == SEL_RXBUF) begin
        rxrdy_reg <= 1'b0;
      end
      case (rx_state_reg)
        RX_IDLE: begin
          // (R6) restart timing at start
          rx_tick_reg <= 4'h0;
          if (rx_on_reg && base_tick && !serial_input_pin) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          // A glitch shorter than half a bit is dropped
          if (rx_mid) begin
            rx_tick_reg  <= 4'h0;
            rx_idx_reg   <= 3'h0;
            rx_state_reg <= serial_input_pin ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_bit_end) begin
            rx_shf_reg <= {serial_input_pin, rx_shf_reg[7:1]};
            rx_idx_reg <= rx_idx_reg + 3'h1;
            if (rx_idx_reg == 3'h7) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          // Store wins over a release in the same cycle
          if (rx_bit_end) begin
            rx_state_reg <= RX_IDLE;
            if (serial_input_pin) begin
              rxb_reg   <= rx_shf_reg;
              rxrdy_reg <= 1'b1;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
      if (!rx_on_reg) begin
        rx_state_reg <= RX_IDLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmitter
  // ---------------------------------------------------------------
  uartc_tx uartc_tx_inst (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .run       (unit_clk_run),
    .base_tick (base_tick),
    .enable    (tx_en),
    .has_data  (txbf_reg),
    .data      (txb_reg),
    .take      (tx_take),
    .busy      (tx_busy),
    .txd       (serial_output_pin)
  );

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_rx_enable_delay;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(rx_on_reg) |-> $past(rx_wait_reg) && $past(base_tick) && $past(power_reg) && $past(rxe_reg);
  endproperty
  a_rx_enable_delay: assert property (p_rx_enable_delay) else $error("rx on too early"); // (R8)

  property p_rx_restart;
    @(posedge sys_clk) disable iff (!nrst)
    (unit_clk_run && rx_state_reg == RX_IDLE && rx_on_reg && power_reg && rxe_reg
      && base_tick && !serial_input_pin)
      |=> (rx_state_reg == RX_START) && (rx_tick_reg == 4'h0);
  endproperty
  a_rx_restart: assert property (p_rx_restart) else $error("start not detected"); // (R6)

  property p_freeze;
    @(posedge sys_clk) disable iff (!nrst)
    !unit_clk_run |=> $stable(rx_state_reg) && $stable(txbf_reg) && $stable(div_reg)
      && $stable(power_reg) && $stable(rxb_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("register moved while stopped"); // (R2)

endmodule // uartc_top

// file: core/uartc_tx.sv
`timescale 1ns/1ps
`include "uartc_map.svh"

module uartc_tx (
  input  wire logic               sys_clk,   // System clock
  input  wire logic               nrst,      // Sync reset, active low
  input  wire logic               run,       // Unit clock supplied
  input  wire logic               base_tick, // Base clock pulse
  input  wire logic               enable,    // Power and transmit enable
  input  wire logic               has_data,  // Transmit buffer full
  input  wire uartc_pkg::uartc_byte_t data,  // Transmit buffer data
  output logic                    take,      // Buffer moved to shifter
  output logic                    busy,      // Frame in progress
  output logic                    txd        // Serial output pin
);
  import uartc_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  uartc_tx_e   state_reg, state_next;   // Engine state
  logic [3:0]  tick_reg, tick_next;     // Ticks within a bit
  logic [2:0]  idx_reg, idx_next;       // Data bit index
  logic [1:0]  gap_reg, gap_next;       // Extra gap ticks
  uartc_byte_t shf_reg, shf_next;       // Shift register
  logic        txd_reg, txd_next;       // Pin level
  wire         bit_end;                 // Last tick of a bit

  assign bit_end = base_tick && (tick_reg == `UC_BIT_TICKS);
  assign busy    = (state_reg != TX_IDLE);
  // (R3) pin is a register, frozen with the rest
  assign txd     = txd_reg;

  // Next state; a frame that follows another waits two extra ticks
  always_comb begin
    state_next = state_reg;
    tick_next  = base_tick ? tick_reg + 4'h1 : tick_reg;
    idx_next   = idx_reg;
    gap_next   = gap_reg;
    shf_next   = shf_reg;
    take       = 1'b0;
    case (state_reg)
      TX_IDLE: begin
        tick_next = 4'h0;
        if (has_data && base_tick) begin
          take       = 1'b1;
          shf_next   = data;
          state_next = TX_START;
        end
      end
      TX_GAP: begin
        tick_next = 4'h0;
        if (base_tick) begin
          gap_next = gap_reg + 2'h1;
          // (R5) two clock gap
          if (gap_reg == `UC_GAP_TICKS - 2'h1) begin
            take       = 1'b1;
            shf_next   = data;
            state_next = TX_START;
          end
        end
      end
      TX_START: begin
        if (bit_end) begin
          state_next = TX_DATA;
          idx_next   = 3'h0;
        end
      end
      TX_DATA: begin
        if (bit_end) begin
          shf_next = {1'b0, shf_reg[7:1]};
          idx_next = idx_reg + 3'h1;
          if (idx_reg == 3'h7) begin
            state_next = TX_STOP;
          end
        end
      end
      TX_STOP: begin
        if (bit_end) begin
          gap_next   = 2'h0;
          // (R5) back-to-back goes via gap
          state_next = has_data ? TX_GAP : TX_IDLE;
        end
      end
      default: begin
        state_next = TX_IDLE;
      end
    endcase
    // (R14) idle high when disabled
    if (!enable) begin
      state_next = TX_IDLE;
      take       = 1'b0;
    end
  end

  // Pin level follows the state being entered
  always_comb begin
    case (state_next)
      TX_START: txd_next = 1'b0;
      TX_DATA:  txd_next = shf_next[0];
      default:  txd_next = 1'b1;
    endcase
  end

  // Registers hold while the unit clock is stopped
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= TX_IDLE;
      tick_reg  <= 4'h0;
      idx_reg   <= 3'h0;
      gap_reg   <= 2'h0;
      shf_reg   <= `UC_RST_BYTE;
      txd_reg   <= 1'b1;
    // (R2) freeze without clock
    end else if (run) begin
      state_reg <= state_next;
      tick_reg  <= tick_next;
      idx_reg   <= idx_next;
      gap_reg   <= gap_next;
      shf_reg   <= shf_next;
      txd_reg   <= txd_next;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_gap_two;
    @(posedge sys_clk) disable iff (!nrst)
    (run && enable && state_reg == TX_STOP && bit_end && has_data)
      |=> (state_reg == TX_GAP) && (gap_reg == 2'h0);
  endproperty
  a_gap_two: assert property (p_gap_two) else $error("gap not entered"); // (R5)

  property p_pin_hold;
    @(posedge sys_clk) disable iff (!nrst)
    !run |=> $stable(txd) && $stable(state_reg) && $stable(shf_reg);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("tx moved while stopped"); // (R3)

  property p_idle_high;
    @(posedge sys_clk) disable iff (!nrst)
    (run && !enable) |=> txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("pin low when disabled"); // (R14)

  property p_bit_step;
    @(posedge sys_clk) disable iff (!nrst)
    (run && enable && state_reg == TX_DATA && bit_end && idx_reg != 3'h7)
      |=> (idx_reg == $past(idx_reg) + 3'h1) && (tick_reg == 4'h0);
  endproperty
  a_bit_step: assert property (p_bit_step) else $error("data bit not advanced"); // (R1)

endmodule // uartc_tx

// file: tb/tb_uartc_top.sv
`timescale 1ns/1ps
module tb_uartc_top;
  logic        sys_clk, nrst, run;          // Clock, reset, unit clock
  logic [3:0]  awaddr, araddr, wstrb;       // Addresses, strobes
  logic [31:0] wdata, rdata, rd_v;          // Bus data, last read
  logic        awv, wv, bready, arv, rready; // Master handshakes
  logic        awr, wrd, bv, arr, rv;       // Slave handshakes
  logic [1:0]  bresp, rresp, rd_r;          // Responses, last read response
  logic        rxd, txd;                    // Serial lines
  int          fail_count, cmp_count, i;    // Tallies, loop index
  uartc_top uartc_top_inst (.sys_clk(sys_clk), .nrst(nrst), .unit_clk_run(run),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready),
    .serial_input_pin(rxd), .serial_output_pin(txd));
  uartc_peer uartc_peer_inst (.sys_clk(sys_clk), .txd_in(txd), .rxd_out(rxd));
  // 50 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // --------------------------------------------------
  // Shared tasks
  // --------------------------------------------------
  task check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task final_report;
    $display("fails=%0d compares=%0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // A wait that ran out ends the run
  task stuck;
    fail_count++;
    final_report();
  endtask
  // Address and data offered together, each dropped once taken
  task wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge sys_clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
      if (bv) break;
    end
    if (n == 99) stuck();
    bready <= 1'b0;
    check(bresp, 2'h0);
  endtask
  task rd(input logic [3:0] a);
    int n;
    @(posedge sys_clk);
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 99; n++) begin
      @(posedge sys_clk);
      if (arr) arv <= 1'b0;
      if (rv) break;
    end
    if (n == 99) stuck();
    rd_v = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask
  // Poll until masked bits match
  task poll(input logic [3:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(a);
      if ((rd_v & m) === v) break;
    end
    if (n == 3000) stuck();
  endtask
  // --------------------------------------------------
  // Main sequence
  // --------------------------------------------------
  initial begin
    {nrst, awaddr, araddr, wstrb, wdata, awv, wv, bready, arv, rready} = '0;
    {run, fail_count, cmp_count} = '0;
    run = 1'b1;
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    check(txd, 1'b1);
    rd(4'h0);
    check(rd_v, 32'h0);
    check(rd_r, 2'h0);
    rd(4'h2);
    check(rd_r, 2'h2);
    check(rd_v, 32'h0);
    wr(4'h0, 32'h80);
    wr(4'h0, 32'hC0);
    repeat (8) @(posedge sys_clk);
    wr(4'h8, 32'hA5);
    poll(4'h4, 32'h2, 32'h0);
    wr(4'h8, 32'h3C); // new byte only; no LIN use here
    rd(4'h4);
    check(rd_v, 32'h3);
    for (i = 0; i < 5000 && uartc_peer_inst.n_got < 2; i++) @(posedge sys_clk);
    if (i == 5000) stuck();
    check(uartc_peer_inst.got[0], 8'hA5);
    check(uartc_peer_inst.got[1], 8'h3C);
    rd(4'h8);
    check(rd_v, 32'h3C);
    check(32'((uartc_peer_inst.t_st[1] - uartc_peer_inst.t_st[0]) / 20), 648);
    wr(4'h0, 32'h80);
    wr(4'h0, 32'hA0);
    repeat (8) @(posedge sys_clk);
    uartc_peer_inst.send(8'h5A, 0);
    poll(4'hC, 32'h100, 32'h100);
    check(rd_v, 32'h15A);
    uartc_peer_inst.send(8'hC3, 300);
    poll(4'hC, 32'h100, 32'h100);
    check(rd_v, 32'h1C3);
    rd(4'hC);
    check(rd_v, 32'hC3);
    wr(4'h0, 32'hC0);
    repeat (8) @(posedge sys_clk);
    wr(4'h8, 32'h00);
    repeat (200) @(posedge sys_clk);
    run <= 1'b0;
    for (i = 0; i < 400; i++) begin
      @(posedge sys_clk);
      check(txd, 1'b0);
    end
    run <= 1'b1;
    rd(4'h0);
    check(rd_v, 32'hC0);
    rd(4'h4);
    check(rd_v, 32'h1);
    wr(4'h0, 32'h80);
    wr(4'h0, 32'h0);
    @(posedge sys_clk);
    check(txd, 1'b1);
    rd(4'h4);
    check(rd_v, 32'h0);
    final_report();
  end
endmodule // tb_uartc_top

// file: tb/uartc_peer.sv
`timescale 1ns/1ps
// Remote node: 8N1, 64 system clocks a bit, LSB first
module uartc_peer (
  input  wire logic sys_clk, // System clock
  input  wire logic txd_in,  // Line from the unit
  output logic      rxd_out  // Line into the unit
);
  logic [7:0] got [0:3];  // Bytes seen on the line
  longint     t_st [0:3]; // Time of each start edge
  int         n_got;      // Bytes seen so far
  logic [7:0] sh;         // Receive shifter
  initial begin
    rxd_out = 1'b1;
    n_got = 0;
  end
  // Sample each bit centre after a start edge
  initial begin
    forever begin
      @(negedge txd_in);
      t_st[n_got % 4] = $time;
      repeat (96) @(posedge sys_clk);
      for (int i = 0; i < 8; i++) begin
        sh[i] = txd_in;
        repeat (64) @(posedge sys_clk);
      end
      got[n_got % 4] = sh;
      n_got++;
    end
  end
  task automatic send(input logic [7:0] b, input int gap);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    repeat (gap) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (64) @(posedge sys_clk);
    end
  endtask
endmodule // uartc_peer
